// File: core/aklb_pkg.sv
/*
 * Package for the ACL lookup key builder: key widths, type codes,
 * selector values, field positions and bus offsets.
 * Assumes nothing of its surroundings.
 */
package aklb_pkg;

    // key classes, in entry words
    localparam int AKLB_WORDS_X4  = 4;
    localparam int AKLB_WORDS_X8  = 8;
    localparam int AKLB_WORDS_X16 = 16;

    // key widths in bits
    localparam int AKLB_W_IPV4_VLAN   = 88;
    localparam int AKLB_W_ETHERTYPE   = 271;
    localparam int AKLB_W_SEVEN_TUPLE = 567;
    localparam int AKLB_ENTRY_W       = 576;

    // eight-word type codes
    localparam logic [3:0] AKLB_X8_ETHERTYPE  = 4'h0;
    localparam logic [3:0] AKLB_X8_ARP        = 4'h3;
    localparam logic [3:0] AKLB_X8_IPV4_TRANS = 4'h4;
    localparam logic [3:0] AKLB_X8_IPV4_MISC  = 4'h5;
    localparam logic [3:0] AKLB_X8_CUSTOM_2   = 4'h8;
    localparam logic [3:0] AKLB_X8_IPV6_VLAN  = 4'h9;

    // sixteen-word type codes
    localparam logic [1:0] AKLB_X16_SEVEN_TUPLE = 2'h1;
    localparam logic [1:0] AKLB_X16_CUSTOM_1    = 2'h2;

    // key selection by software
    typedef enum logic [1:0] {
        AKLB_KEY_IPV4_VLAN,
        AKLB_KEY_ETHERTYPE,
        AKLB_KEY_SEVEN_TUPLE
    } aklb_key_e;

    // port mask selector values
    localparam logic [1:0] AKLB_SEL_DEFAULT  = 2'h0;
    localparam logic [1:0] AKLB_SEL_LOOPBACK = 2'h1;
    localparam logic [1:0] AKLB_SEL_MASQ     = 2'h2;
    localparam logic [1:0] AKLB_SEL_SPECIAL  = 2'h3;

    // mask layout for selector 3
    localparam int AKLB_MASK_W     = 53;
    localparam int AKLB_MSK_SRC_LO = 4;
    localparam int AKLB_MSK_PT_LO  = 44;
    localparam int AKLB_MSK_ACT_LO = 49;
    localparam int AKLB_MAC_MC_BIT = 40;

    localparam logic [2:0] AKLB_ACT_MASQ_INJECT = 3'h1;
    localparam logic [7:0] AKLB_PAG_RST         = 8'h00;

    // register byte offsets
    localparam logic [3:0] AKLB_REG_CTRL   = 4'h0;
    localparam logic [3:0] AKLB_REG_STATUS = 4'h4;

endpackage

// File: core/aklb_top.sv
/*
 * ACL lookup key builder: packs classified frame fields into lookup
 * entries and derives the ingress source mask.
 * Assumes the classifier holds its inputs stable while FRM_VALID is high
 * and software programs control over classic Wishbone.
 */
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Keys come in four, eight and sixteen word classes.
// - The IPv4 VLAN, ethertype and seven-tuple keys are 88, 271 and 567 bits wide.
// - Fields are packed in order from entry bit 0 upward.
// - In an ethertype entry the type code sits at bits 3:0 and the lookup flag at bit 4.
// - Eight-word type codes are 0, 3, 4, 5, 8 and 9 for the six eight-word keys.
// - Sixteen-word type codes are 1 for seven-tuple and 2 for the first custom key.
// - Each key has a flag set for the first lookup and clear for the second.
// - Each key holds an 8-bit policy group defaulting to the port's setting.
// - The selector is 0 by default and 1 for loopback frames.
// - The selector is 2 for masqueraded frames when the masquerade enable is set.
// - The selector is 3 for enabled CPU, virtual device or loopback-sel3 frames.
// - The highest qualifying selector wins.
// - Selectors 0 to 2 mark the physical, looped or masqueraded port in the mask.
// - Selector 3 mask carries source flags, source port, pipeline point and action.
// - The multicast bit copies destination MAC bit 40.
module aklb_top
    import aklb_pkg::*;
#(
    parameter int PORTS = 53
) (
    input  wire logic                    CLK,          // 100 MHz clock
    input  wire logic                    SRST,         // sync reset, high
    input  wire logic                    CE,           // clock enable
    input  wire logic [3:0]              WB_ADR_I,     // byte address
    input  wire logic [31:0]             WB_DAT_I,     // write data
    output logic      [31:0]             WB_DAT_O,     // read data
    input  wire logic                    WB_WE_I,      // write enable
    input  wire logic [3:0]              WB_SEL_I,     // byte lanes
    input  wire logic                    WB_STB_I,     // strobe
    input  wire logic                    WB_CYC_I,     // cycle
    output logic                         WB_ACK_O,     // acknowledge
    input  wire logic                    FRM_VALID,    // frame fields valid
    input  wire logic                    FIRST_LOOKUP, // first lookup
    input  wire logic [7:0]              PORT_DEFAULT_POLICY_GROUP, // per port
    input  wire logic                    POLICY_GROUP_OVR, // classified group valid
    input  wire logic [7:0]              POLICY_GROUP, // classified group
    input  wire logic [47:0]             DMAC,         // destination MAC
    input  wire logic [5:0]              PHYS_PORT,    // physical port
    input  wire logic [5:0]              SRC_PORT,     // injected source port
    input  wire logic [5:0]              LOOPED_PORT,  // looped port
    input  wire logic                    INJECTED,     // injected frame
    input  wire logic                    CPU_INJECTED, // cpu injected
    input  wire logic                    LOOPBACK_DEVICE, // from loopback
    input  wire logic                    PROCESSOR_PORT_ZERO, // src processor_port_zero
    input  wire logic                    PROCESSOR_PORT_ONE,  // src processor_port_one
    input  wire logic                    VIRTUAL_DEVICE_ZERO, // src vd0
    input  wire logic                    VIRTUAL_DEVICE_ONE,  // src vd1
    input  wire logic [4:0]              PIPELINE_POINT,  // pipeline point
    input  wire logic [2:0]              PIPELINE_ACTION, // pipeline action
    output logic                         KEY_VALID,    // entry valid
    output logic [AKLB_ENTRY_W-1:0]      KEY_ENTRY,    // packed entry
    output logic [4:0]                   KEY_WORDS     // entry word count
);

    /****************************************
     * state
     ****************************************/
    typedef struct packed {
        logic                    ack;
        logic [31:0]             rdat;
        aklb_key_e               key_sel;
        logic                    masq_ena;
        logic                    cpu_ena;
        logic                    vd_ena;
        logic                    lbk3_ena;
        logic [1:0]              last_sel;
        logic [15:0]             key_count;
        logic                    vld;
        logic [AKLB_ENTRY_W-1:0] entry;
        logic [4:0]              words;
    } aklb_state_s;

    aklb_state_s st_reg;
    aklb_state_s st_next;

    logic [1:0]             sel;
    logic [AKLB_MASK_W-1:0] mask;
    logic [7:0]             policy_group;
    logic                   mc;
    logic                   masq;
    logic [63:0]            onehot;

    /****************************************
     * selector and mask
     ****************************************/
    always_comb begin
        masq = (INJECTED && (SRC_PORT != PHYS_PORT)) || (PIPELINE_ACTION == AKLB_ACT_MASQ_INJECT);
        if ((CPU_INJECTED && st_reg.cpu_ena)
            || ((VIRTUAL_DEVICE_ZERO || VIRTUAL_DEVICE_ONE) && st_reg.vd_ena)
            || (LOOPBACK_DEVICE && st_reg.lbk3_ena)) begin
            sel = AKLB_SEL_SPECIAL;
        end else if (masq && st_reg.masq_ena) begin
            sel = AKLB_SEL_MASQ;
        end else if (LOOPBACK_DEVICE) begin
            sel = AKLB_SEL_LOOPBACK;
        end else begin
            sel = AKLB_SEL_DEFAULT;
        end
        mask = '0;
        onehot = '0;
        case (sel)
            AKLB_SEL_DEFAULT:  onehot[PHYS_PORT] = 1'b1;
            AKLB_SEL_LOOPBACK: onehot[LOOPED_PORT] = 1'b1;
            AKLB_SEL_MASQ:     onehot[SRC_PORT] = 1'b1;
            default:           onehot = '0;
        endcase
        if (sel == AKLB_SEL_SPECIAL) begin
            mask[0] = PROCESSOR_PORT_ZERO;
            mask[1] = PROCESSOR_PORT_ONE;
            mask[2] = VIRTUAL_DEVICE_ZERO;
            mask[3] = VIRTUAL_DEVICE_ONE;
            mask[AKLB_MSK_SRC_LO +: 6] = SRC_PORT;
            mask[AKLB_MSK_PT_LO +: 5]  = PIPELINE_POINT;
            mask[AKLB_MSK_ACT_LO +: 3] = PIPELINE_ACTION;
        end else begin
            mask = onehot[AKLB_MASK_W-1:0];
        end
        policy_group = POLICY_GROUP_OVR ? POLICY_GROUP : PORT_DEFAULT_POLICY_GROUP;
        mc = DMAC[AKLB_MAC_MC_BIT];
    end

    /****************************************
     * next state
     ****************************************/
    always_comb begin
        st_next = st_reg;
        st_next.ack = 1'b0;
        // wishbone slave, one wait state
        if (WB_CYC_I && WB_STB_I && !st_reg.ack) begin
            st_next.ack = 1'b1;
            st_next.rdat = '0;
            case (WB_ADR_I)
                AKLB_REG_CTRL: begin
                    if (WB_WE_I && WB_SEL_I[0]) begin
                        st_next.key_sel  = aklb_key_e'(WB_DAT_I[1:0]);
                        st_next.masq_ena = WB_DAT_I[4];
                        st_next.cpu_ena  = WB_DAT_I[5];
                        st_next.vd_ena   = WB_DAT_I[6];
                        st_next.lbk3_ena = WB_DAT_I[7];
                    end
                    st_next.rdat[7:0] = {st_reg.lbk3_ena, st_reg.vd_ena, st_reg.cpu_ena,
                                         st_reg.masq_ena, 2'b00, st_reg.key_sel};
                end
                AKLB_REG_STATUS: begin
                    st_next.rdat = {14'h0000, st_reg.last_sel, st_reg.key_count};
                end
                default: st_next.rdat = '0;
            endcase
        end
        st_next.vld = FRM_VALID;
        if (FRM_VALID) begin
            st_next.last_sel = sel;
            st_next.key_count = st_reg.key_count + 16'h0001;
            st_next.entry = '0;
            case (st_reg.key_sel)
                AKLB_KEY_ETHERTYPE: begin
                    st_next.entry[3:0] = AKLB_X8_ETHERTYPE;
                    st_next.entry[4] = FIRST_LOOKUP;
                    st_next.entry[12:5] = policy_group;
                    st_next.entry[14:13] = sel;
                    st_next.entry[67:15] = mask;
                    st_next.entry[68] = mc;
                    st_next.words = 5'(AKLB_WORDS_X8);
                end
                AKLB_KEY_SEVEN_TUPLE: begin
                    st_next.entry[1:0] = AKLB_X16_SEVEN_TUPLE;
                    st_next.entry[2] = FIRST_LOOKUP;
                    st_next.entry[10:3] = policy_group;
                    st_next.entry[12:11] = sel;
                    st_next.entry[65:13] = mask;
                    st_next.entry[66] = mc;
                    st_next.words = 5'(AKLB_WORDS_X16);
                end
                default: begin
                    st_next.entry[0] = FIRST_LOOKUP;
                    st_next.entry[8:1] = policy_group;
                    st_next.words = 5'(AKLB_WORDS_X4);
                end
            endcase
        end
        if (SRST) begin
            st_next = '0;
            st_next.key_sel = AKLB_KEY_IPV4_VLAN;
        end
    end

    always_ff @(posedge CLK) begin
        if (CE || SRST) begin
            st_reg <= st_next;
        end
    end

    assign WB_ACK_O  = st_reg.ack;
    assign WB_DAT_O  = st_reg.rdat;
    assign KEY_VALID = st_reg.vld;
    assign KEY_ENTRY = st_reg.entry;
    assign KEY_WORDS = st_reg.words;

    /****************************************
     * checks
     ****************************************/
    a_width_four: assert property (@(posedge CLK) disable iff (SRST)
        KEY_VALID && KEY_WORDS == 5'h04 |-> KEY_ENTRY[AKLB_ENTRY_W-1:AKLB_W_IPV4_VLAN] == '0)
        else $error("four word key too wide");
    a_width_eight: assert property (@(posedge CLK) disable iff (SRST)
        KEY_VALID && KEY_WORDS == 5'h08 |-> KEY_ENTRY[AKLB_ENTRY_W-1:AKLB_W_ETHERTYPE] == '0)
        else $error("eight word key too wide");
    a_width_sixteen: assert property (@(posedge CLK) disable iff (SRST)
        KEY_VALID && KEY_WORDS == 5'h10 |-> KEY_ENTRY[AKLB_ENTRY_W-1:AKLB_W_SEVEN_TUPLE] == '0)
        else $error("sixteen word key too wide");
    a_word_class: assert property (@(posedge CLK) disable iff (SRST)
        KEY_VALID |-> (KEY_WORDS == 5'h04 || KEY_WORDS == 5'h08 || KEY_WORDS == 5'h10))
        else $error("word class wrong");
    a_first_flag: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && st_reg.key_sel == AKLB_KEY_IPV4_VLAN |=> KEY_ENTRY[0] == $past(FIRST_LOOKUP))
        else $error("lookup flag wrong");
    a_pag_classified: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && POLICY_GROUP_OVR && st_reg.key_sel == AKLB_KEY_ETHERTYPE
        |=> KEY_ENTRY[12:5] == $past(POLICY_GROUP)) else $error("classified group wrong");
    a_default_sel: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && !LOOPBACK_DEVICE && !(masq && st_reg.masq_ena) && !(CPU_INJECTED && st_reg.cpu_ena)
        && !((VIRTUAL_DEVICE_ZERO || VIRTUAL_DEVICE_ONE) && st_reg.vd_ena) |=> st_reg.last_sel == 2'h0)
        else $error("default selector wrong");
    a_vd_sel: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && (VIRTUAL_DEVICE_ZERO || VIRTUAL_DEVICE_ONE) && st_reg.vd_ena
        |=> st_reg.last_sel == 2'h3) else $error("virtual device selector wrong");
    a_lbk3_sel: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && LOOPBACK_DEVICE && st_reg.lbk3_ena |=> st_reg.last_sel == 2'h3)
        else $error("loopback sel3 selector wrong");
    a_phys_mark: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && st_reg.key_sel == AKLB_KEY_ETHERTYPE && sel == 2'h0
        |=> KEY_ENTRY[67:15] == (53'h1 << $past(PHYS_PORT))) else $error("physical port mark wrong");
    a_looped_mark: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && st_reg.key_sel == AKLB_KEY_ETHERTYPE && sel == 2'h1
        |=> KEY_ENTRY[67:15] == (53'h1 << $past(LOOPED_PORT))) else $error("looped port mark wrong");
    a_masq_mark: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && st_reg.key_sel == AKLB_KEY_ETHERTYPE && sel == 2'h2
        |=> KEY_ENTRY[67:15] == (53'h1 << $past(SRC_PORT))) else $error("masquerade port mark wrong");
    a_special_flags: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && st_reg.key_sel == AKLB_KEY_ETHERTYPE && sel == 2'h3
        |=> KEY_ENTRY[18:15] == {$past(VIRTUAL_DEVICE_ONE), $past(VIRTUAL_DEVICE_ZERO),
                                 $past(PROCESSOR_PORT_ONE), $past(PROCESSOR_PORT_ZERO)})
        else $error("source flags wrong");
    a_special_fields: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && st_reg.key_sel == AKLB_KEY_ETHERTYPE && sel == 2'h3
        |=> KEY_ENTRY[24:19] == $past(SRC_PORT) && KEY_ENTRY[58:25] == '0
        && KEY_ENTRY[63:59] == $past(PIPELINE_POINT) && KEY_ENTRY[66:64] == $past(PIPELINE_ACTION)
        && !KEY_ENTRY[67]) else $error("special mask fields wrong");
    a_tuple_mc: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && st_reg.key_sel == AKLB_KEY_SEVEN_TUPLE |=> KEY_ENTRY[66] == $past(DMAC[40]))
        else $error("tuple multicast bit wrong");

    a_ack_one_cycle: assert property (@(posedge CLK) disable iff (SRST)
        WB_ACK_O && CE |=> !WB_ACK_O) else $error("ack held too long");
    a_loop_sel: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && LOOPBACK_DEVICE && !st_reg.lbk3_ena && !CPU_INJECTED
        && !VIRTUAL_DEVICE_ZERO && !VIRTUAL_DEVICE_ONE && !masq |=> st_reg.last_sel == 2'h1)
        else $error("loopback selector wrong");
    a_masq_sel: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && masq && st_reg.masq_ena && sel != 2'h3 |=> st_reg.last_sel == 2'h2)
        else $error("masquerade selector wrong");
    a_cpu_sel: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && CPU_INJECTED && st_reg.cpu_ena |=> st_reg.last_sel == 2'h3)
        else $error("cpu selector wrong");
    a_etype_code: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && st_reg.key_sel == AKLB_KEY_ETHERTYPE
        |=> KEY_ENTRY[3:0] == 4'h0 && KEY_ENTRY[4] == $past(FIRST_LOOKUP) && KEY_WORDS == 5'h08)
        else $error("ethertype header wrong");
    a_tuple_code: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && st_reg.key_sel == AKLB_KEY_SEVEN_TUPLE
        |=> KEY_ENTRY[1:0] == 2'h1 && KEY_WORDS == 5'h10) else $error("tuple header wrong");
    a_mc_bit: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && st_reg.key_sel == AKLB_KEY_ETHERTYPE |=> KEY_ENTRY[68] == $past(DMAC[40]))
        else $error("multicast bit wrong");
    a_upper_zero: assert property (@(posedge CLK) disable iff (SRST)
        KEY_VALID |-> KEY_ENTRY[AKLB_ENTRY_W-1:69] == '0) else $error("upper bits not zero");
    a_pag_default: assert property (@(posedge CLK) disable iff (SRST)
        FRM_VALID && CE && !POLICY_GROUP_OVR && st_reg.key_sel == AKLB_KEY_IPV4_VLAN
        |=> KEY_ENTRY[8:1] == $past(PORT_DEFAULT_POLICY_GROUP)) else $error("policy group wrong");

endmodule

`default_nettype wire

// File: bench/aklb_frame_src.sv
/*
 * Frame source model standing in for the classifier in front of the key builder.
 * Assumes the bench calls drive once per frame and idle after the last one.
 */
`timescale 1ns/1ps
`default_nettype none
module aklb_frame_src (
    input  wire logic        clk,       // bench clock
    output logic             frm_valid, // frame strobe
    output logic             first_lk,  // first lookup
    output logic [7:0]       pdpg,      // port default group
    output logic             pg_ovr,    // classified group valid
    output logic [7:0]       pg,        // classified group
    output logic [47:0]      dmac,      // destination mac
    output logic [5:0]       phys,      // physical port
    output logic [5:0]       src,       // source port
    output logic [5:0]       looped,    // looped port
    output logic [6:0]       flags,     // inj cpu lbk processor_port_zero processor_port_one vd0 vd1
    output logic [4:0]       pt,        // pipeline point
    output logic [2:0]       act        // pipeline action
);
    initial {frm_valid, first_lk, pdpg, pg_ovr, pg, dmac, phys, src, looped, flags, pt, act} = '0;
    // fields held whole cycle with the strobe
    task automatic drive(inout int seed);
        @(posedge clk);
        frm_valid <= 1'b1;
        {first_lk, pg_ovr, flags, pt, act} <= 17'($random(seed));
        {pdpg, pg} <= 16'($random(seed));
        dmac <= {16'($random(seed)), 32'($random(seed))};
        phys <= 6'(($random(seed) & 32'h7fff_ffff) % 53);
        src <= 6'(($random(seed) & 32'h7fff_ffff) % 53);
        looped <= 6'(($random(seed) & 32'h7fff_ffff) % 53);
    endtask
    task automatic idle();
        @(posedge clk);
        frm_valid <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: bench/acl_lookup_key_builder_tb_top.sv
/*
 * Self-checking bench of the key builder: random frames, wishbone control.
 * Assumes the frame source model and the design package are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module acl_lookup_key_builder_tb_top;
    import aklb_pkg::*;
    logic CLK = 0, SRST = 1, ce = 1, cyc = 0, stb = 0, we = 0, ack, fv, fl, ovr, kv;
    logic [3:0] adr = 0, sel = 0;
    logic [31:0] wdat = 0, rdat, q;
    logic [7:0] pdpg, pg, ctl;
    logic [47:0] dmac;
    logic [5:0] phys, src, lp;
    logic [6:0] fg;
    logic [4:0] pt, kw;
    logic [2:0] act;
    logic [575:0] ke;
    logic [575:0] q_e[$];
    logic [4:0] q_w[$];
    logic [1:0] last_s;
    int n_fail = 0, checks = 0, cycles = 0, n_frm = 0, seed = 32'h3adc_474f;
    initial forever #5 CLK = ~CLK;
    aklb_frame_src u_aklb_frame_src (.clk(CLK), .frm_valid(fv), .first_lk(fl), .pdpg(pdpg), .pg_ovr(ovr),
        .pg(pg), .dmac(dmac), .phys(phys), .src(src), .looped(lp), .flags(fg), .pt(pt), .act(act));
    aklb_top u_aklb_top (.CLK(CLK), .SRST(SRST), .CE(ce), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_WE_I(we), .WB_SEL_I(sel), .WB_STB_I(stb), .WB_CYC_I(cyc), .WB_ACK_O(ack), .FRM_VALID(fv),
        .FIRST_LOOKUP(fl), .PORT_DEFAULT_POLICY_GROUP(pdpg), .POLICY_GROUP_OVR(ovr), .POLICY_GROUP(pg),
        .DMAC(dmac), .PHYS_PORT(phys), .SRC_PORT(src), .LOOPED_PORT(lp), .INJECTED(fg[6]),
        .CPU_INJECTED(fg[5]), .LOOPBACK_DEVICE(fg[4]), .PROCESSOR_PORT_ZERO(fg[3]), .PROCESSOR_PORT_ONE(fg[2]),
        .VIRTUAL_DEVICE_ZERO(fg[1]), .VIRTUAL_DEVICE_ONE(fg[0]), .PIPELINE_POINT(pt), .PIPELINE_ACTION(act),
        .KEY_VALID(kv), .KEY_ENTRY(ke), .KEY_WORDS(kw));
    task automatic chk(input string nm, input logic [575:0] s, input logic [575:0] e);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic conclude();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge CLK);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
        do begin
            @(posedge CLK);
        end while (ack !== 1'b1);
        r = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    // expected entry from frame fields and control shadow
    task automatic expect_frame();
        logic [575:0] e;
        logic [52:0] m;
        logic [7:0] g;
        logic [1:0] s;
        logic [4:0] w;
        e = '0;
        g = ovr ? pg : pdpg;
        s = AKLB_SEL_DEFAULT;
        if (fg[4]) s = AKLB_SEL_LOOPBACK;
        if (ctl[4] && ((fg[6] && src != phys) || act == AKLB_ACT_MASQ_INJECT)) s = AKLB_SEL_MASQ;
        if ((ctl[5] && fg[5]) || (ctl[6] && (fg[1] || fg[0])) || (ctl[7] && fg[4])) s = AKLB_SEL_SPECIAL;
        m = '0;
        case (s)
            2'h0: m[phys] = 1'b1;
            2'h1: m[lp] = 1'b1;
            2'h2: m[src] = 1'b1;
            default: m = {1'b0, act, pt, 34'h0_0000_0000, src, fg[0], fg[1], fg[2], fg[3]};
        endcase
        case (ctl[1:0])
            2'h0: begin
                e[8:0] = {g, fl};
                w = 5'h04;
            end
            2'h1: begin
                e[68:0] = {dmac[40], m, s, g, fl, AKLB_X8_ETHERTYPE};
                w = 5'h08;
            end
            default: begin
                e[66:0] = {dmac[40], m, s, g, fl, AKLB_X16_SEVEN_TUPLE};
                w = 5'h10;
            end
        endcase
        q_e.push_back(e);
        q_w.push_back(w);
        last_s = s;
        n_frm++;
    endtask
    always @(posedge CLK) begin
        cycles++;
        if (kv === 1'b1) begin
            if (q_e.size() == 0) chk("unexpected key", 1, 0);
            else begin
                chk("key entry", ke, q_e.pop_front());
                chk("key words", 576'(kw), 576'(q_w.pop_front()));
            end
        end
        if (cycles == 20000) begin
            n_fail++;
            conclude();
        end
    end
    initial begin
        ctl = 8'h00;
        repeat (10) @(posedge CLK);
        SRST <= 1'b0;
        for (int k = 0; k < 12; k++) begin
            ctl = {4'($random(seed)), 2'b00, 2'(k % 3)};
            wb(1'b1, AKLB_REG_CTRL, {24'h00_0000, ctl}, q);
            repeat (40) begin
                u_aklb_frame_src.drive(seed);
                #1 expect_frame();
            end
            u_aklb_frame_src.idle();
            repeat (3) @(posedge CLK);
            // frame offered while frozen must leave no key
            ce <= 1'b0;
            u_aklb_frame_src.drive(seed);
            u_aklb_frame_src.idle();
            @(posedge CLK);
            ce <= 1'b1;
            wb(1'b0, AKLB_REG_STATUS, 32'h0000_0000, q);
            chk("status", 576'(q[17:0]), 576'({last_s, 16'(n_frm)}));
            wb(1'b0, AKLB_REG_CTRL, 32'h0000_0000, q);
            chk("ctrl", 576'(q), 576'(ctl));
            wb(1'b0, 4'h8, 32'h0000_0000, q);
            chk("unmapped", 576'(q), 576'h0);
            chk("queue left", 576'(q_e.size()), 576'h0);
            $display("test %0d done", k);
        end
        // mid-run reset clears count, selector and control
        SRST <= 1'b1;
        @(posedge CLK);
        SRST <= 1'b0;
        wb(1'b0, AKLB_REG_STATUS, 32'h0000_0000, q);
        chk("status after reset", 576'(q), 576'h0);
        wb(1'b0, AKLB_REG_CTRL, 32'h0000_0000, q);
        chk("ctrl after reset", 576'(q), 576'h0);
        $display("reset test done");
        conclude();
    end
endmodule
`default_nettype wire
